// >>> common/pwm_pkg.sv
// Shared constants for the ten-channel pulse-width modulator.
// Assumes a single core clock and a plain strobe register port.
package pwm_pkg;
   localparam int NUM_CH = 10;
   localparam int NUM_ALT = 8;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int CNT_W = 12;
   localparam int SETUP_W = 9;
   // Register offsets on the plain port.
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] DATA_ADDR = 4'h1;
   localparam logic [3:0] SYNC_ADDR = 4'h2;
   // Control/pointer field positions.
   localparam int PTR_LSB = 0;
   localparam int SEL_LSB = 4;
   localparam int EN_BIT = 6;
   localparam int UPD_BIT = 7;
   // Local register selector codes; bit 1 alone picks the delay.
   localparam logic [1:0] SEL_DUTY = 2'h0;
   localparam logic [1:0] SEL_SETUP = 2'h1;
   // Channel setup field positions.
   localparam int RES_LSB = 0;
   localparam int INV_BIT = 3;
   localparam int ALT_BIT = 4;
   localparam int CLK_LSB = 5;
   localparam int FOUR_SLOT_SPREAD_BIT = 7;
   localparam int THIRTY_TWO_SLOT_SPREAD_BIT = 8;
   // Clock source codes; code 3 also selects the external clock.
   localparam logic [1:0] CLK_CORE = 2'h0;
   localparam logic [1:0] CLK_PERIPH = 2'h1;
   // Resolution: code 0 is 7 bits, code 5 and above is 12 bits.
   localparam logic [3:0] RES_MIN = 4'h7;
   localparam logic [3:0] RES_MAX = 4'hC;
   localparam logic [2:0] RES_CODE_MAX = 3'h5;
   localparam logic [3:0] SHIFT_4 = 4'h2;
   localparam logic [3:0] SHIFT_32 = 4'h5;
   // Reset values.
   localparam logic [11:0] DUTY_RST = 12'h000;
   localparam logic [8:0] SETUP_RST = 9'h000;
   localparam logic [11:0] DELAY_RST = 12'h000;
   // Channel engine states, Gray coded along idle, delay, run.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DELAY = 2'h1,
      ST_RUN = 2'h3
   } chan_state_t;
endpackage

// >>> dv/pwm_ctrl_bench.sv
// Bench for the pulse-width modulator: registers, waveforms and sync.
// Assumes the load model integrates PWM line one on the core clock.
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_bench;
   localparam logic [3:0] ca = pwm_pkg::CTRL_ADDR;
   localparam logic [3:0] da = pwm_pkg::DATA_ADDR;
   localparam logic [3:0] sa = pwm_pkg::SYNC_ADDR;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic tick = 1'b0;
   logic ext = 1'b0;
   logic ext_run = 1'b0;
   logic clear = 1'b0;
   logic use_alt = 1'b0;
   logic [15:0] rdata;
   logic [9:0] pwm;
   logic [7:0] alt;
   int level;
   int miscompares = 0;
   int samples_checked = 0;
   wire line = use_alt ? alt[1] : pwm[1];
   // Core clock, plus peripheral tick or external clock at half rate.
   // Only one of the two runs at a time, so a swapped source stalls the channel.
   always #5 clk = ~clk;
   always @(posedge clk) begin
      tick <= ext_run ? 1'b0 : ~tick;
      ext <= ext_run ? ~ext : 1'b0;
   end
   pwm_ctrl u_pwm_ctrl (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .PERIPH_TICK_IN(tick), .EXT_CLK_IN(ext), .PWM_OUT(pwm), .PWM_ALT_OUT(alt));
   pwm_load_model u_pwm_load_model (.clk_in(clk), .clear_in(clear), .line_in(line),
      .level_out(level));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // One bus cycle; consecutive calls give back-to-back strobes.
   task op(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
   endtask
   task wrr(input logic [3:0] a, input logic [15:0] d);
      op(1'b1, a, d);
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so look there.
   task rdc(input logic [3:0] a, input logic [15:0] e);
      op(1'b0, a, 16'h0000);
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Whole-frame windows ignore phase; short ones start at count 7 after cfg.
   task meas(input int n, input int e);
      @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      repeat (n) @(posedge clk);
      #1 chk(16'(level), 16'(e));
   endtask
   // Disabling first makes the final enable restart the channel.
   task cfg(input logic [3:0] ch, input logic [15:0] s, input logic [15:0] d);
      wrr(ca, {12'h001, ch});
      wrr(da, s);
      wrr(ca, {12'h000, ch});
      wrr(da, d);
      wrr(ca, {12'h00C, ch});
      repeat (8) @(posedge clk);
   endtask
   task t_regs;
      rdc(ca, 16'h0000);
      wrr(ca, 16'h0032);
      op(1'b1, da, 16'hF123);
      rdc(ca, 16'h0033);
      wrr(ca, 16'h0022);
      rdc(da, 16'h0123);
      op(1'b0, ca, 16'h0000);
      op(1'b0, da, 16'h0000);
      rdc(ca, 16'h0024);
      wrr(ca, 16'h000F);
      rdc(da, 16'h0000);
      rdc(ca, 16'h0000);
      wrr(4'h7, 16'hFFFF);
      rdc(4'h5, 16'h0000);
      op(1'b1, sa, 16'h0200);
      rdc(sa, 16'h0200);
      rdc(sa, 16'h0000);
      op(1'b1, ca, 16'h0005);
      rdc(ca, 16'h0005);
      $display("regs done");
   endtask
   task wave(input logic [15:0] s, d, input logic a, input int n, e);
      use_alt <= a;
      cfg(4'h1, s, d);
      meas(n, e);
   endtask
   task t_wave;
      wave(16'h0000, 16'h0002, 1'b0, 256, 4);
      wave(16'h0000, 16'h0F85, 1'b0, 256, 10);
      wave(16'h0002, 16'h0080, 1'b0, 512, 128);
      wave(16'h0008, 16'h0002, 1'b0, 256, 252);
      wave(16'h0010, 16'h0002, 1'b1, 256, 4);
      wave(16'h0020, 16'h0002, 1'b0, 512, 8);
      ext_run <= 1'b1;
      wave(16'h0040, 16'h0002, 1'b0, 512, 8);
      ext_run <= 1'b0;
      wave(16'h0085, 16'h0100, 1'b0, 1024, 64);
      wave(16'h0185, 16'h0100, 1'b0, 128, 8);
      wave(16'h0080, 16'h000B, 1'b0, 121, 8);
      wave(16'h0180, 16'h000B, 1'b0, 121, 8);
      // Start delay of 20 after masking; the window ends inside the first pulse.
      wrr(ca, 16'h0021);
      wrr(da, 16'h0F94);
      wave(16'h0000, 16'h000B, 1'b0, 20, 7);
      wrr(ca, 16'h0021);
      wrr(da, 16'h0000);
      use_alt <= 1'b0;
      $display("wave done");
   endtask
   // Both channels share one setup, as sync demands of software.
   task t_sync;
      cfg(4'h0, 16'h0000, 16'h0002);
      cfg(4'h1, 16'h0000, 16'h0002);
      wrr(sa, 16'h0003);
      repeat (8) @(posedge clk);
      // After the sync both pins show count 6 + k at step k of this loop.
      for (int k = 0; k < 128; k++) begin
         @(posedge clk);
         #1 chk({15'h0000, pwm[0]}, {15'h0000, (k + 6) % 128 < 2});
         chk({15'h0000, pwm[1]}, {15'h0000, (k + 6) % 128 < 2});
      end
      wrr(ca, 16'h0000);
      meas(256, 4);
      chk({15'h0000, pwm[0]}, 16'h0000);
      $display("sync done");
   endtask
   task complete_run;
      $display("checked %0d bad %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Main sequence, then a watchdog well beyond the expected run.
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_wave();
      t_sync();
      complete_run();
   end
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire

// >>> dv/pwm_ctrl_props.sv
// Port checker for the pulse-width modulator register port and pins.
// Assumes one core clock and the plain strobe register port.
`timescale 1ns/1ps
`default_nettype none
module pwm_ctrl_props #(
   parameter int NUM_CH = 10,
   parameter int NUM_ALT = 8
) (
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [3:0] REG_ADDR_IN,
   input wire logic [15:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [15:0] REG_RDATA_OUT,
   input wire logic [NUM_CH-1:0] PWM_OUT,
   input wire logic [NUM_ALT-1:0] PWM_ALT_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Decoded strobes keep the properties short.
   wire rd_ctrl = REG_RD_IN && REG_ADDR_IN == 4'h0;
   wire rd_data = REG_RD_IN && REG_ADDR_IN == 4'h1;
   wire rd_sync = REG_RD_IN && REG_ADDR_IN == 4'h2;
   wire wr_ctrl = REG_WR_IN && REG_ADDR_IN == 4'h0;
   wire wr_sync = REG_WR_IN && REG_ADDR_IN == 4'h2;
   rd_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 16'h0000)
      else $error("read data without read");
   unmapped_zero_a: assert property (REG_RD_IN && REG_ADDR_IN > 4'h2 |=> REG_RDATA_OUT == 16'h0000)
      else $error("unmapped read not zero");
   ctrl_upper_a: assert property (rd_ctrl |=> REG_RDATA_OUT[15:7] == 9'h000)
      else $error("control upper bits set");
   sync_clear_a: assert property (rd_sync && !$past(wr_sync) |=> REG_RDATA_OUT == 16'h0000)
      else $error("sync not cleared");
   sync_hold_a: assert property (wr_sync ##1 rd_sync
      |=> REG_RDATA_OUT == {6'h00, $past(REG_WDATA_IN[9:0], 2)})
      else $error("sync value lost");
   alt_excl_a: assert property ((PWM_OUT[NUM_ALT-1:0] & PWM_ALT_OUT) == '0)
      else $error("both pins high");
   ptr_step_a: assert property (rd_ctrl ##1 rd_data ##1 rd_ctrl
      |=> REG_RDATA_OUT[3:0] == $past(REG_RDATA_OUT[3:0], 2) + 4'h1)
      else $error("pointer did not advance");
   ctrl_back_a: assert property (wr_ctrl && REG_WDATA_IN[3:0] < 4'hA ##1 rd_ctrl
      |=> REG_RDATA_OUT[6:0] == $past(REG_WDATA_IN[6:0], 2))
      else $error("control readback wrong");
   // Main scenarios reached.
   cover property (wr_sync ##1 rd_sync);
   cover property (rd_ctrl ##1 rd_data ##1 rd_ctrl);
   cover property (|PWM_ALT_OUT);
endmodule
bind pwm_ctrl pwm_ctrl_props #(.NUM_CH(NUM_CH), .NUM_ALT(NUM_ALT)) u_props (
   .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
   .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .PWM_OUT(PWM_OUT), .PWM_ALT_OUT(PWM_ALT_OUT));
`default_nettype wire

// >>> dv/pwm_load_model.sv
// Load model: a filter that integrates the high time of one PWM line.
// Assumes the line is sampled on the core clock; clear restarts the sum.
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
   input wire logic clk_in,
   input wire logic clear_in,
   input wire logic line_in,
   output var int level_out
);
   // A filter only sees the average, so the high cycles are summed.
   always @(posedge clk_in) level_out <= clear_in ? 0 : level_out + int'(line_in);
endmodule
`default_nettype wire

// >>> rtl/pwm_ctrl.sv
// Ten-channel pulse-width modulator with pointer-based local registers.
// Assumes all inputs are synchronous to REF_CLK_IN and strobes are one cycle.
`timescale 1ns/1ps
`default_nettype none

module pwm_ctrl #(
   parameter int NUM_CH = pwm_pkg::NUM_CH,
   parameter int NUM_ALT = pwm_pkg::NUM_ALT
) (
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [pwm_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [pwm_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [pwm_pkg::DATA_W-1:0] REG_RDATA_OUT,
   input wire logic PERIPH_TICK_IN,
   input wire logic EXT_CLK_IN,
   output logic [NUM_CH-1:0] PWM_OUT,
   output logic [NUM_ALT-1:0] PWM_ALT_OUT
);

   // Frame mask from the resolution code; larger codes clamp to twelve bits.
   function automatic logic [11:0] res_mask(input logic [2:0] code);
      case (code)
         3'h0: res_mask = 12'h07F;
         3'h1: res_mask = 12'h0FF;
         3'h2: res_mask = 12'h1FF;
         3'h3: res_mask = 12'h3FF;
         3'h4: res_mask = 12'h7FF;
         default: res_mask = 12'hFFF;
      endcase
   endfunction

   // Slot shift: 0 plain, 2 for four slots, 5 for thirty-two slots.
   function automatic logic [3:0] slot_shift(input logic [8:0] setup);
      logic big;
      logic four_slot_spread_bit;
      logic thirty_two_slot_spread_bit;
      big = (setup[pwm_pkg::RES_LSB +: 3] >= pwm_pkg::RES_CODE_MAX);
      four_slot_spread_bit = setup[pwm_pkg::FOUR_SLOT_SPREAD_BIT];
      thirty_two_slot_spread_bit = setup[pwm_pkg::THIRTY_TWO_SLOT_SPREAD_BIT];
      // Below twelve bits the wide option falls back to four slots.
      if (four_slot_spread_bit && thirty_two_slot_spread_bit && big) begin
         slot_shift = pwm_pkg::SHIFT_32;
      end else if (four_slot_spread_bit) begin
         slot_shift = pwm_pkg::SHIFT_4;
      end else begin
         slot_shift = 4'h0;
      end
   endfunction

   // High test for one count; the remainder goes to the first slots.
   function automatic logic wave_high(input logic [11:0] cnt, input logic [11:0] duty,
                                      input logic [3:0] res, input logic [3:0] sh);
      logic [11:0] pmask;
      logic [11:0] smask;
      logic [11:0] slot;
      logic [11:0] lim;
      pmask = (12'h001 << (res - sh)) - 12'h001;
      smask = (12'h001 << sh) - 12'h001;
      slot = cnt >> (res - sh);
      lim = (duty >> sh) + {11'h000, (slot < (duty & smask))};
      if (sh == 4'h0) begin
         wave_high = (cnt < duty);
      end else begin
         wave_high = ((cnt & pmask) < lim);
      end
   endfunction

   logic [3:0] ptr;
   logic [1:0] sel;
   logic [NUM_CH-1:0] sync;
   logic [pwm_pkg::DATA_W-1:0] rdata;
   logic ext_prev;
   logic [3:0] next_ptr;
   logic [1:0] next_sel;
   logic [NUM_CH-1:0] next_sync;
   logic [pwm_pkg::DATA_W-1:0] next_rdata;
   logic ctl_wr;
   logic data_wr;
   logic data_rd;
   logic ext_tick;
   logic [11:0] duty_a [NUM_CH];
   logic [8:0] setup_a [NUM_CH];
   logic [11:0] delay_a [NUM_CH];
   logic [NUM_CH-1:0] en_a;

   assign ctl_wr = REG_WR_IN && (REG_ADDR_IN == pwm_pkg::CTRL_ADDR);
   assign data_wr = REG_WR_IN && (REG_ADDR_IN == pwm_pkg::DATA_ADDR);
   assign data_rd = REG_RD_IN && (REG_ADDR_IN == pwm_pkg::DATA_ADDR);
   // The external clock is taken as synchronous, so one flop finds its rising edge.
   assign ext_tick = EXT_CLK_IN && !ext_prev;
   assign REG_RDATA_OUT = rdata;

   // Pointer, sync and read data; pointers 10 to 15 reach nothing and read zero.
   always_comb begin
      next_ptr = ptr;
      next_sel = sel;
      next_sync = '0;
      next_rdata = '0;
      if (ctl_wr) begin
         next_ptr = REG_WDATA_IN[pwm_pkg::PTR_LSB +: 4];
         next_sel = REG_WDATA_IN[pwm_pkg::SEL_LSB +: 2];
      end else if (REG_WR_IN && (REG_ADDR_IN == pwm_pkg::SYNC_ADDR)) begin
         next_sync = REG_WDATA_IN[NUM_CH-1:0];
      end else if (data_wr || data_rd) begin
         next_ptr = ptr + 4'h1;
      end
      if (REG_RD_IN) begin
         if (REG_ADDR_IN == pwm_pkg::CTRL_ADDR) begin
            next_rdata[pwm_pkg::PTR_LSB +: 4] = ptr;
            next_rdata[pwm_pkg::SEL_LSB +: 2] = sel;
            if (ptr < NUM_CH) begin
               next_rdata[pwm_pkg::EN_BIT] = en_a[ptr];
            end
         end else if (REG_ADDR_IN == pwm_pkg::DATA_ADDR) begin
            if (ptr < NUM_CH) begin
               if (sel[1]) begin
                  next_rdata[11:0] = delay_a[ptr];
               end else if (sel == pwm_pkg::SEL_SETUP) begin
                  next_rdata[8:0] = setup_a[ptr];
               end else begin
                  next_rdata[11:0] = duty_a[ptr];
               end
            end
         end else if (REG_ADDR_IN == pwm_pkg::SYNC_ADDR) begin
            next_rdata[NUM_CH-1:0] = sync;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ptr <= 4'h0;
         sel <= 2'h0;
         sync <= '0;
         rdata <= '0;
         ext_prev <= 1'b0;
      end else begin
         ptr <= next_ptr;
         sel <= next_sel;
         sync <= next_sync;
         rdata <= next_rdata;
         ext_prev <= EXT_CLK_IN;
      end
   end

   // One local register set and one counting engine per channel.
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [11:0] duty;
      logic [8:0] setup;
      logic [11:0] delay;
      logic [11:0] act;
      logic en;
      logic en_d;
      pwm_pkg::chan_state_t st;
      logic [11:0] cnt;
      logic [11:0] dly;
      logic pin;
      logic altp;
      logic [11:0] next_duty;
      logic [8:0] next_setup;
      logic [11:0] next_delay;
      logic [11:0] next_act;
      logic next_en;
      pwm_pkg::chan_state_t next_st;
      logic [11:0] next_cnt;
      logic [11:0] next_dly;
      logic next_pin;
      logic next_altp;
      logic [11:0] mask;
      logic [3:0] sh;
      logic [3:0] res;
      logic tick;
      logic wave;
      logic out;
      logic use_alt;

      assign duty_a[i] = duty;
      assign setup_a[i] = setup;
      assign delay_a[i] = delay;
      assign en_a[i] = en;

      always_comb begin
         next_duty = duty;
         next_setup = setup;
         next_delay = delay;
         next_act = act;
         next_en = en;
         next_st = st;
         next_cnt = cnt;
         next_dly = dly;
         mask = res_mask(setup[pwm_pkg::RES_LSB +: 3]);
         sh = slot_shift(setup);
         res = pwm_pkg::RES_MIN + {1'b0, setup[pwm_pkg::RES_LSB +: 3]};
         if (setup[pwm_pkg::RES_LSB +: 3] > pwm_pkg::RES_CODE_MAX) begin
            res = pwm_pkg::RES_MAX;
         end
         // Clock source picks the counting enable.
         case (setup[pwm_pkg::CLK_LSB +: 2])
            pwm_pkg::CLK_CORE: tick = 1'b1;
            pwm_pkg::CLK_PERIPH: tick = PERIPH_TICK_IN;
            default: tick = ext_tick;
         endcase
         // Data window write lands in the pointed channel only.
         if (data_wr && (ptr == i)) begin
            if (sel[1]) begin
               next_delay = REG_WDATA_IN[11:0];
            end else if (sel == pwm_pkg::SEL_SETUP) begin
               next_setup = REG_WDATA_IN[8:0];
            end else begin
               next_duty = REG_WDATA_IN[11:0];
            end
         end
         // The running duty changes only on an explicit update, never mid-write.
         if (ctl_wr && (REG_WDATA_IN[pwm_pkg::PTR_LSB +: 4] == i)) begin
            next_en = REG_WDATA_IN[pwm_pkg::EN_BIT];
            if (REG_WDATA_IN[pwm_pkg::UPD_BIT]) begin
               next_act = duty;
            end
         end
         // Restart on enable or sync; phase alignment assumes matching setups.
         if (!en) begin
            next_st = pwm_pkg::ST_IDLE;
            next_cnt = 12'h000;
            next_dly = 12'h000;
         end else if (sync[i] || !en_d) begin
            next_st = pwm_pkg::ST_DELAY;
            next_cnt = 12'h000;
            next_dly = (delay & mask) >> sh;
         end else if (tick) begin
            case (st)
               pwm_pkg::ST_DELAY: begin
                  if (dly == 12'h000) begin
                     next_st = pwm_pkg::ST_RUN;
                  end else begin
                     next_dly = dly - 12'h001;
                  end
               end
               pwm_pkg::ST_RUN: begin
                  next_cnt = (cnt == mask) ? 12'h000 : cnt + 12'h001;
               end
               default: next_st = pwm_pkg::ST_DELAY;
            endcase
         end
         wave = (st == pwm_pkg::ST_RUN) && wave_high(cnt, act & mask, res, sh);
         out = wave ^ setup[pwm_pkg::INV_BIT];
         use_alt = (i < NUM_ALT) && setup[pwm_pkg::ALT_BIT];
         next_pin = use_alt ? 1'b0 : out;
         next_altp = use_alt ? out : 1'b0;
      end

      always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
         if (!RST_N_IN) begin
            duty <= pwm_pkg::DUTY_RST;
            setup <= pwm_pkg::SETUP_RST;
            delay <= pwm_pkg::DELAY_RST;
            act <= pwm_pkg::DUTY_RST;
            en <= 1'b0;
            en_d <= 1'b0;
            st <= pwm_pkg::ST_IDLE;
            cnt <= 12'h000;
            dly <= 12'h000;
            pin <= 1'b0;
            altp <= 1'b0;
         end else begin
            duty <= next_duty;
            setup <= next_setup;
            delay <= next_delay;
            act <= next_act;
            en <= next_en;
            en_d <= en;
            st <= next_st;
            cnt <= next_cnt;
            dly <= next_dly;
            pin <= next_pin;
            altp <= next_altp;
         end
      end

      assign PWM_OUT[i] = pin;
      if (i < NUM_ALT) begin : g_alt
         assign PWM_ALT_OUT[i] = altp;
      end
   end

endmodule

`default_nettype wire
